// *** cpu_opcode_decode_tail.sv ***
// Decode and execute sequencer for test, transfer and wait instructions
// Function
// - Test sets N,Z only, five opcodes
// - 9F copies index to accumulator, 2 cycles
// - 8F clears I, halts until interrupt
// - Classify opcode groups by high nibble
// - 16-bit offset: high then low, plus index
// - 8-bit offset unsigned, added to index
// - Extended: fetch address high then low
// - Bit branch: direct byte then offset
`timescale 1ns/1ps
module cpu_opcode_decode_tail
  import opdec_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // Program memory byte stream
  input  wire logic        mem_valid_i,
  input  wire logic [7:0]  mem_data_i,
  input  wire logic [15:0] mem_base_pc_i,
  output logic             fetch_req_o,
  output logic [15:0]      fetch_addr_o,
  // Datapath state in
  input  wire logic [7:0]  operand_data_i,
  input  wire logic        bit_cond_i,
  input  wire logic        irq_i,
  // Results out
  output logic [7:0]       acc_o,
  output logic [7:0]       index_o,
  output logic [7:0]       condition_code_reg_o,
  output logic [15:0]      pc_o,
  output logic [15:0]      eff_addr_o,
  output logic             eff_valid_o,
  output logic             cpu_clk_en_o,
  output logic             illegal_op_o,
  output logic             instr_done_o
);
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_OPND1  = 3'b001,
    ST_OPND2  = 3'b010,
    ST_EXEC   = 3'b011,
    ST_WAIT   = 3'b100
  } seq_state_t;

  typedef struct packed {
    seq_state_t  st;
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [1:0]  need;
    logic [3:0]  cyc;
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic [7:0]  condition_code_reg;
    logic [15:0] pc;
    logic [15:0] ea;
    logic        ea_v;
    logic        fetch;
    logic        clk_en;
    logic        illegal;
    logic        done;
  } dec_state_t;

  dec_state_t s_reg, s_next;
  logic [1:0] nbytes;
  logic       bad;

  opdec_classify u_classify (
    .opcode_i     (mem_data_i),
    .group_o      (),
    .mode_o       (),
    .opnd_bytes_o (nbytes),
    .illegal_o    (bad)
  );

  function automatic logic [3:0] cycles_of(input logic [7:0] op);
    case (op)
      OP_TEST_DIR:            cycles_of = CYC_TEST_DIR;
      OP_TEST_ACC,
      OP_TEST_IDX:            cycles_of = CYC_TEST_REG;
      OP_TEST_IX1:            cycles_of = CYC_TEST_IX1;
      OP_TEST_IX:             cycles_of = CYC_TEST_IX;
      OP_IDX_TO_A, OP_WAIT,
      OP_TAX:                 cycles_of = CYC_INH2;
      default:                cycles_of = CYC_DEFAULT;
    endcase
  endfunction : cycles_of

  function automatic logic [7:0] nz_flags(input logic [7:0] cc, input logic [7:0] v);
    logic [7:0] r;
    r       = cc;
    r[CC_N] = v[7];
    r[CC_Z] = (v == ZERO8);
    nz_flags = r;
  endfunction : nz_flags

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next         = s_reg;
    s_next.done    = 1'b0;
    s_next.illegal = 1'b0;
    s_next.fetch   = 1'b0;
    case (s_reg.st)
      ST_OPCODE: begin
        s_next.fetch = 1'b1;
        s_next.ea_v  = 1'b0;
        if (mem_valid_i) begin
          s_next.op   = mem_data_i;
          s_next.pc   = mem_base_pc_i + 16'h0001;
          s_next.need = nbytes;
          s_next.cyc  = cycles_of(mem_data_i) - 4'h1;
          if (bad) begin
            s_next.illegal = 1'b1;
            s_next.done    = 1'b1;
            s_next.fetch   = 1'b1;
          end else if (nbytes != 2'd0) begin
            s_next.st = ST_OPND1;
          end else begin
            s_next.st = ST_EXEC;
          end
        end
      end
      ST_OPND1: begin
        s_next.fetch = 1'b1;
        if (mem_valid_i) begin
          s_next.b1  = mem_data_i;
          s_next.pc  = s_reg.pc + 16'h0001;
          s_next.cyc = (s_reg.cyc != 4'h0) ? s_reg.cyc - 4'h1 : 4'h0;
          s_next.st  = (s_reg.need == 2'd2) ? ST_OPND2 : ST_EXEC;
          s_next.fetch = (s_reg.need == 2'd2);
          if (s_reg.op[7:4] == 4'h6 || s_reg.op[7:4] == 4'he) begin
            s_next.ea   = {8'h00, mem_data_i} + {8'h00, s_reg.idx};
            s_next.ea_v = 1'b1;
          end else if (s_reg.op[7:5] != 3'b110 && s_reg.op[7:4] != 4'h0) begin
            s_next.ea   = {8'h00, mem_data_i};
            s_next.ea_v = (s_reg.op[7:4] != 4'h2) && (s_reg.op[7:4] != 4'ha);
          end
        end
      end
      ST_OPND2: begin
        s_next.fetch = 1'b1;
        if (mem_valid_i) begin
          s_next.b2    = mem_data_i;
          s_next.pc    = s_reg.pc + 16'h0001;
          s_next.st    = ST_EXEC;
          s_next.fetch = 1'b0;
          if (s_reg.op[7:4] == 4'hc) begin
            s_next.ea   = {s_reg.b1, mem_data_i};
            s_next.ea_v = 1'b1;
          end else if (s_reg.op[7:4] == 4'hd) begin
            s_next.ea   = {s_reg.b1, mem_data_i} + {8'h00, s_reg.idx};
            s_next.ea_v = 1'b1;
          end else if (s_reg.op[7:4] == 4'h0) begin
            s_next.ea   = {8'h00, s_reg.b1};
            s_next.ea_v = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        if (s_reg.cyc > 4'h1) begin
          s_next.cyc = s_reg.cyc - 4'h1;
        end else begin
          s_next.done = 1'b1;
          s_next.st   = ST_OPCODE;
          s_next.fetch = 1'b1;
          case (s_reg.op)
            OP_TEST_ACC: s_next.condition_code_reg = nz_flags(s_reg.condition_code_reg, s_reg.acc);
            OP_TEST_IDX: s_next.condition_code_reg = nz_flags(s_reg.condition_code_reg, s_reg.idx);
            OP_TEST_DIR, OP_TEST_IX1, OP_TEST_IX:
              s_next.condition_code_reg = nz_flags(s_reg.condition_code_reg, operand_data_i);
            OP_IDX_TO_A: s_next.acc = s_reg.idx;
            OP_TAX:      s_next.idx = s_reg.acc;
            OP_WAIT: begin
              s_next.condition_code_reg[CC_I] = 1'b0;
              s_next.clk_en    = 1'b0;
              s_next.st        = ST_WAIT;
              s_next.done      = 1'b0;
              s_next.fetch     = 1'b0;
            end
            default: begin
              if (s_reg.op[7:4] == 4'h0 && bit_cond_i) begin
                s_next.pc = s_reg.pc + {{8{s_reg.b2[7]}}, s_reg.b2};
              end
            end
          endcase
        end
      end
      ST_WAIT: begin
        // Wake only on interrupt; stacking handled elsewhere
        if (irq_i) begin
          s_next.clk_en = 1'b1;
          s_next.done   = 1'b1;
          s_next.st     = ST_OPCODE;
          s_next.fetch  = 1'b1;
        end
      end
      default: s_next.st = ST_OPCODE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_reg        <= '0;
      s_reg.st     <= ST_OPCODE;
      s_reg.condition_code_reg    <= CC_RESET;
      s_reg.clk_en <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign fetch_req_o          = s_reg.fetch;
  assign fetch_addr_o         = s_reg.pc;
  assign acc_o                = s_reg.acc;
  assign index_o              = s_reg.idx;
  assign condition_code_reg_o = s_reg.condition_code_reg;
  assign pc_o                 = s_reg.pc;
  assign eff_addr_o           = s_reg.ea;
  assign eff_valid_o          = s_reg.ea_v;
  assign cpu_clk_en_o         = s_reg.clk_en;
  assign illegal_op_o         = s_reg.illegal;
  assign instr_done_o         = s_reg.done;
endmodule : cpu_opcode_decode_tail

// *** opdec_pkg.sv ***
// Shared constants and types for the opcode decode tail
package opdec_pkg;
  // Opcode values
  localparam logic [7:0] OP_TEST_DIR  = 8'h3d;
  localparam logic [7:0] OP_TEST_ACC  = 8'h4d;
  localparam logic [7:0] OP_TEST_IDX  = 8'h5d;
  localparam logic [7:0] OP_TEST_IX1  = 8'h6d;
  localparam logic [7:0] OP_TEST_IX   = 8'h7d;
  localparam logic [7:0] OP_WAIT      = 8'h8f;
  localparam logic [7:0] OP_TAX       = 8'h97;
  localparam logic [7:0] OP_IDX_TO_A  = 8'h9f;
  // Cycle counts
  localparam logic [3:0] CYC_TEST_DIR = 4'h4;
  localparam logic [3:0] CYC_TEST_REG = 4'h3;
  localparam logic [3:0] CYC_TEST_IX1 = 4'h5;
  localparam logic [3:0] CYC_TEST_IX  = 4'h4;
  localparam logic [3:0] CYC_INH2     = 4'h2;
  localparam logic [3:0] CYC_DEFAULT  = 4'h3;
  // Condition code bit positions
  localparam int CC_C = 0;
  localparam int CC_Z = 1;
  localparam int CC_N = 2;
  localparam int CC_I = 3;
  localparam int CC_H = 4;
  // Reset values
  localparam logic [7:0] CC_RESET     = 8'he8;
  localparam logic [7:0] ZERO8        = 8'h00;

  typedef enum logic [3:0] {
    GRP_BITMAN  = 4'h0,
    GRP_BRANCH  = 4'h1,
    GRP_RMW     = 4'h2,
    GRP_CONTROL = 4'h3,
    GRP_REGMEM  = 4'h4
  } op_group_t;

  typedef enum logic [2:0] {
    MODE_INH    = 3'h0,
    MODE_IMM    = 3'h1,
    MODE_DIR    = 3'h2,
    MODE_EXT    = 3'h3,
    MODE_IX2    = 3'h4,
    MODE_IX1    = 3'h5,
    MODE_IX     = 3'h6,
    MODE_REL    = 3'h7
  } addr_mode_t;
endpackage : opdec_pkg

// *** opdec_classify.sv ***
// Combinational opcode classifier by high nibble
`timescale 1ns/1ps
module opdec_classify
  import opdec_pkg::*;
(
  // Opcode in
  input  wire logic [7:0] opcode_i,
  // Classification out
  output op_group_t       group_o,
  output addr_mode_t      mode_o,
  output logic [1:0]      opnd_bytes_o,
  output logic            illegal_o
);
  always_comb begin
    group_o      = GRP_REGMEM;
    mode_o       = MODE_INH;
    opnd_bytes_o = 2'd0;
    illegal_o    = 1'b0;
    case (opcode_i[7:4])
      4'h0, 4'h1: begin
        group_o      = GRP_BITMAN;
        mode_o       = MODE_DIR;
        opnd_bytes_o = (opcode_i[7:4] == 4'h0) ? 2'd2 : 2'd1;
      end
      4'h2: begin
        group_o      = GRP_BRANCH;
        mode_o       = MODE_REL;
        opnd_bytes_o = 2'd1;
      end
      4'h3, 4'h6: begin
        group_o      = GRP_RMW;
        mode_o       = (opcode_i[7:4] == 4'h3) ? MODE_DIR : MODE_IX1;
        opnd_bytes_o = 2'd1;
      end
      4'h4, 4'h5, 4'h7: begin
        group_o = GRP_RMW;
        mode_o  = (opcode_i[7:4] == 4'h7) ? MODE_IX : MODE_INH;
      end
      4'h8, 4'h9: begin
        group_o = GRP_CONTROL;
      end
      4'ha: begin
        mode_o       = MODE_IMM;
        opnd_bytes_o = 2'd1;
      end
      4'hb: begin
        mode_o       = MODE_DIR;
        opnd_bytes_o = 2'd1;
      end
      4'hc: begin
        mode_o       = MODE_EXT;
        opnd_bytes_o = 2'd2;
      end
      4'hd: begin
        mode_o       = MODE_IX2;
        opnd_bytes_o = 2'd2;
      end
      4'he: begin
        mode_o       = MODE_IX1;
        opnd_bytes_o = 1'b1 ? 2'd1 : 2'd0;
      end
      default: begin
        mode_o = MODE_IX;
      end
    endcase
    case (opcode_i)
      8'h31, 8'h41, 8'h51, 8'h61, 8'h71,
      8'h32, 8'h52, 8'h62, 8'h72,
      8'h35, 8'h45, 8'h55, 8'h65, 8'h75,
      8'h3b, 8'h4b, 8'h5b, 8'h6b, 8'h7b,
      8'h3e, 8'h4e, 8'h5e, 8'h6e, 8'h7e,
      8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b,
      8'h8c, 8'h8d, 8'h82,
      8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96,
      8'ha7, 8'hac, 8'haf: illegal_o = 1'b1;
      default:             illegal_o = 1'b0;
    endcase
  end
endmodule : opdec_classify

// *** prog_mem.sv ***
// Program memory model feeding opcode and operand bytes
`timescale 1ns/1ps
module prog_mem (
  // Clock
  input  wire logic        sys_clk_i,
  // Fetch side
  input  wire logic        fetch_req_i,
  input  wire logic [15:0] fetch_addr_i,
  // Bench control
  input  wire logic [15:0] limit_i,
  input  wire logic        slow_i,
  // Byte stream out
  output logic             mem_valid_o,
  output logic [7:0]       mem_data_o
);
  ////////////////////////////////////////
  logic [7:0] mem [256];
  logic       gap_reg  = 1'b0;
  logic [7:0] last_reg = 8'h00;
  always @(posedge sys_clk_i) begin
    gap_reg <= slow_i & ~gap_reg;
    if (mem_valid_o) last_reg <= mem_data_o;
  end
  // Bytes past the loaded end are withheld
  assign mem_valid_o = fetch_req_i && (fetch_addr_i < limit_i) && !gap_reg;
  // Idle bus shows the inverted last byte, never stale data
  assign mem_data_o  = mem_valid_o ? mem[fetch_addr_i[7:0]] : ~last_reg;
endmodule : prog_mem

// *** opdec_monitor.sv ***
// Port checker for the decode tail
`timescale 1ns/1ps
module opdec_monitor
  import opdec_pkg::*;
(
  // Watched ports
  input wire logic       sys_clk_i,
  input wire logic       srst_i,
  input wire logic       mem_valid_i,
  input wire logic [7:0] mem_data_i,
  input wire logic       fetch_req_o,
  input wire logic       irq_i,
  input wire logic [7:0] acc_o,
  input wire logic [7:0] index_o,
  input wire logic [7:0] condition_code_reg_o,
  input wire logic       cpu_clk_en_o,
  input wire logic       illegal_op_o,
  input wire logic       instr_done_o
);
  ////////////////////////////////////////
  logic       idle_reg;
  wire  logic take = (idle_reg | instr_done_o) & mem_valid_i & fetch_req_o;
  wire  logic [7:0] cc = condition_code_reg_o;
  // Opcode slot tracking, so operand bytes never count as opcodes
  always_ff @(posedge sys_clk_i) idle_reg <= srst_i | (~take & (idle_reg | instr_done_o));
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence took(logic [7:0] op);
    take && mem_data_i == op;
  endsequence
  xfer_copy_a:
    assert property (took(OP_IDX_TO_A) |-> ##2 instr_done_o && acc_o == $past(index_o, 2))
    else $error("index copy wrong");
  test_acc_a:
    assert property (took(OP_TEST_ACC) |-> ##3 instr_done_o && cc[CC_Z] == (acc_o == 8'h00)
      && cc[CC_N] == acc_o[7]) else $error("accumulator test flags wrong");
  test_keep_a:
    assert property (took(OP_TEST_IDX) |-> ##3 ((cc ^ $past(cc, 3)) & 8'h19) == 8'h00)
    else $error("test changed other flags");
  test_dir_a:
    assert property (took(OP_TEST_DIR) |-> ##4 instr_done_o) else $error("direct test timing");
  wait_mask_a:
    assert property (took(OP_WAIT) |-> ##2 !cc[CC_I]) else $error("wait kept mask");
  wake_up_a:
    assert property (!cpu_clk_en_o && irq_i |-> ##[1:2] cpu_clk_en_o) else $error("no wake");
  blank_flag_a:
    assert property (took(8'h31) |-> ##[1:2] illegal_op_o) else $error("blank not flagged");
  blank_quiet_a:
    assert property (illegal_op_o |-> $stable(acc_o) && $stable(cc)) else $error("blank acted");
endmodule : opdec_monitor

bind cpu_opcode_decode_tail opdec_monitor mon (.*);

// *** tb.sv ***
// Self-checking bench for the decode tail
`timescale 1ns/1ps
module tb;
  import opdec_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic        irq       = 1'b0;
  logic        bcond     = 1'b0;
  logic        slow      = 1'b0;
  logic [7:0]  opnd      = 8'h00;
  logic [7:0]  idx_exp   = 8'h00;
  logic [15:0] limit     = 16'h0000;
  logic [15:0] pc_exp    = 16'h0000;
  logic [7:0]  cc_exp    = CC_RESET;
  logic        mem_valid, fetch_req, eff_valid, clk_en, ill, done, saw_ill, ea_ok;
  logic [7:0]  mem_data, acc, idx, condition_code_reg;
  logic [15:0] fetch_addr, pc, eff_addr;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc;
  int          tick = 0;
  ////////////////////////////////////////
  prog_mem pmem (.sys_clk_i(sys_clk_i), .fetch_req_i(fetch_req), .fetch_addr_i(fetch_addr),
    .limit_i(limit), .slow_i(slow), .mem_valid_o(mem_valid), .mem_data_o(mem_data));
  cpu_opcode_decode_tail dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .mem_valid_i(mem_valid),
    .mem_data_i(mem_data), .mem_base_pc_i(fetch_addr), .fetch_req_o(fetch_req),
    .fetch_addr_o(fetch_addr), .operand_data_i(opnd), .bit_cond_i(bcond), .irq_i(irq),
    .acc_o(acc), .index_o(idx), .condition_code_reg_o(condition_code_reg), .pc_o(pc), .eff_addr_o(eff_addr),
    .eff_valid_o(eff_valid), .cpu_clk_en_o(clk_en), .illegal_op_o(ill), .instr_done_o(done));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // Loads one instruction, releases it, counts edges from opcode to done
  task automatic run(input logic [7:0] b0, b1, b2, d, input logic [15:0] n);
    logic st;
    st = 1'b0;
    pmem.mem[pc_exp[7:0]] = b0;
    pmem.mem[pc_exp[7:0] + 8'h01] = b1;
    pmem.mem[pc_exp[7:0] + 8'h02] = b2;
    @(posedge sys_clk_i);
    limit <= pc_exp + n;
    opnd <= d;
    saw_ill = 1'b0;
    repeat (24) begin
      @(negedge sys_clk_i);
      saw_ill |= ill;
      if (st) cyc++;
      if (!st && mem_valid) begin
        st = 1'b1;
        cyc = 0;
      end
      if (st && done) begin
        ea_ok = eff_valid;
        break;
      end
    end
    @(negedge sys_clk_i);
    pc_exp = pc_exp + n;
  endtask : run
  task automatic t_class();
    // Byte count and address use per nibble, seen through the whole decoder
    logic [15:0] ln [16] = '{16'h3, 16'h2, 16'h2, 16'h2, 16'h1, 16'h1, 16'h2, 16'h1, 16'h1,
      16'h1, 16'h2, 16'h2, 16'h3, 16'h3, 16'h2, 16'h1};
    logic [15:0] adr = 16'h784b;
    for (int i = 0; i < 16; i++) begin
      run({4'(i), (i == 9) ? 4'h7 : 4'h0}, 8'h10, 8'h20, 8'h00, ln[i]);
      check("group length", pc_exp, pc);
      check("group address", {15'h0000, adr[i]}, {15'h0000, ea_ok});
    end
    $display("Classify done");
  endtask : t_class
  task automatic t_test();
    logic [7:0]  op [5] = '{OP_TEST_DIR, OP_TEST_ACC, OP_TEST_IDX, OP_TEST_IX1, OP_TEST_IX};
    logic [7:0]  od [5] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h80};
    logic [7:0]  ev [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80};
    logic [3:0]  cy [5] = '{CYC_TEST_DIR, CYC_TEST_REG, CYC_TEST_REG, CYC_TEST_IX1, CYC_TEST_IX};
    logic [15:0] ln [5] = '{16'h2, 16'h1, 16'h1, 16'h2, 16'h1};
    for (int i = 0; i < 5; i++) begin
      run(op[i], 8'h40, 8'h00, od[i], ln[i]);
      cc_exp = (cc_exp & 8'hf9) | {5'h00, ev[i][7], ev[i] == 8'h00, 1'b0};
      check("test cycles", {12'h000, cy[i]}, 16'(cyc));
      check("test flags", {8'h00, cc_exp}, {8'h00, condition_code_reg});
    end
    $display("Test forms done");
  endtask : t_test
  task automatic t_misc();
    run(OP_IDX_TO_A, 8'h00, 8'h00, 8'h55, 16'h1);
    check("xfer cycles", {12'h000, CYC_INH2}, 16'(cyc));
    check("xfer acc", {8'h00, idx_exp}, {8'h00, acc});
    check("xfer flags", {8'h00, cc_exp}, {8'h00, condition_code_reg});
    run(8'h31, 8'h00, 8'h00, 8'h00, 16'h1);
    check("blank flag", 16'h0001, {15'h0000, saw_ill});
    check("blank flags", {8'h00, cc_exp}, {8'h00, condition_code_reg});
    run(OP_WAIT, 8'h00, 8'h00, 8'h00, 16'h1);
    cc_exp[CC_I] = 1'b0;
    check("wait halt", 16'h0000, {15'h0000, clk_en});
    check("wait flags", {8'h00, cc_exp}, {8'h00, condition_code_reg});
    @(posedge sys_clk_i);
    irq <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    irq <= 1'b0;
    @(negedge sys_clk_i);
    check("wait wake", 16'h0001, {15'h0000, clk_en});
    $display("Transfer, blank and wait done");
  endtask : t_misc
  task automatic t_addr();
    @(posedge sys_clk_i);
    slow <= 1'b1;
    run(8'hc7, 8'h12, 8'h34, 8'h00, 16'h3);
    check("ext addr", 16'h1234, eff_addr);
    check("ext valid", 16'h0001, {15'h0000, ea_ok});
    @(posedge sys_clk_i);
    slow <= 1'b0;
    run(8'hd7, 8'h01, 8'h20, 8'h00, 16'h3);
    check("ix2 addr", 16'h0120 + {8'h00, idx_exp}, eff_addr);
    run(8'he7, 8'hf0, 8'h00, 8'h00, 16'h2);
    check("ix1 addr", 16'h00f0 + {8'h00, idx_exp}, eff_addr);
    @(posedge sys_clk_i);
    bcond <= 1'b1;
    // Forward target, so no stale byte below the fetch limit is taken
    run(8'h00, 8'h40, 8'h04, 8'h00, 16'h3);
    pc_exp = pc_exp + 16'h0004;
    check("branch taken", pc_exp, pc);
    @(posedge sys_clk_i);
    bcond <= 1'b0;
    run(8'h01, 8'h40, 8'h05, 8'h00, 16'h3);
    check("branch skip", pc_exp, pc);
    $display("Address and branch done");
  endtask : t_addr
  ////////////////////////////////////////
  always #4 sys_clk_i = ~sys_clk_i;
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk_i) begin
    tick <= tick + 1;
    if (tick == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_class();
    t_test();
    t_misc();
    t_addr();
    stop_test();
  end
endmodule : tb
